// file: design/cmp_ctrl_pkg.sv
// Constants, field layouts and carriers for the comparator control wrapper.
// Assumes a 32-bit AXI4-Lite register bus and a 20 MHz sys_clk.
package cmp_ctrl_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CONTROL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] MASK_OFS = 4'h8;
  localparam int ENABLE_BIT = 15;
  localparam int DRIVE_BIT = 14;
  localparam int POLARITY_BIT = 13;
  localparam int RESULT_BIT = 8;
  localparam int EDGE_LSB = 6;
  localparam int POSSEL_BIT = 4;
  localparam int NEGSEL_LSB = 0;
  localparam logic [31:0] CONTROL_WMASK = 32'h0000_E0D3;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_00C3;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic enable;
    logic driveEnable;
    logic polarityInvert;
    logic [1:0] edgeSelect;
    logic positiveSelect;
    logic [1:0] negativeSelect;
  } control_s;

  typedef struct packed {
    logic enable;
    logic positiveSelect;
    logic [1:0] negativeSelect;
  } analog_s;
endpackage

// file: design/comparator_control_interrupt.sv
// Comparator control wrapper: control register, result sync, edge interrupt.
// Assumes the analogue core result is asynchronous to sys_clk.
`timescale 1ns/1ns
module comparator_control_interrupt (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // AXI4-Lite write address and data
  input wire logic [cmp_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [cmp_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analogue core
  input wire logic comparatorResult,
  output cmp_ctrl_pkg::analog_s analogControl,
  // Pin and interrupt
  output logic resultOutputPin,
  output logic resultOutputPinOe,
  output logic irq
);

  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_HAVE = 3'b010,
    W_RESP = 3'b100
  } wstate_e;

  cmp_ctrl_pkg::control_s ctrl_r, ctrl_nxt;
  wstate_e wState_r, wState_nxt;
  logic awHave_r, awHave_nxt, wHave_r, wHave_nxt;
  logic [cmp_ctrl_pkg::ADDR_W-1:0] awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic [3:0] wStrb_r, wStrb_nxt;
  logic [1:0] bResp_r, bResp_nxt;
  logic rValid_r, rValid_nxt;
  logic [31:0] rData_r, rData_nxt;
  logic [1:0] rResp_r, rResp_nxt;
  logic sync1_r, sync2_r, prev_r, prev_nxt;
  logic status_r, status_nxt, mask_r, mask_nxt;
  logic pin_r, pin_nxt, pinOe_r, pinOe_nxt, irq_r, irq_nxt;
  logic awReady_r, awReady_nxt, wReady_r, wReady_nxt;
  logic bValid_r, bValid_nxt, arReady_r, arReady_nxt;
  logic edgePulse, shaped;

  // Byte-lane merge of write data
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] ctrlWord(input cmp_ctrl_pkg::control_s c,
      input logic res);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[cmp_ctrl_pkg::ENABLE_BIT] = c.enable;
    w[cmp_ctrl_pkg::DRIVE_BIT] = c.driveEnable;
    w[cmp_ctrl_pkg::POLARITY_BIT] = c.polarityInvert;
    w[cmp_ctrl_pkg::RESULT_BIT] = res;
    w[cmp_ctrl_pkg::EDGE_LSB +: 2] = c.edgeSelect;
    w[cmp_ctrl_pkg::POSSEL_BIT] = c.positiveSelect;
    w[cmp_ctrl_pkg::NEGSEL_LSB +: 2] = c.negativeSelect;
    return w;
  endfunction

  function automatic cmp_ctrl_pkg::control_s toCtrl(input logic [31:0] w);
    cmp_ctrl_pkg::control_s c;
    c.enable = w[cmp_ctrl_pkg::ENABLE_BIT];
    c.driveEnable = w[cmp_ctrl_pkg::DRIVE_BIT];
    c.polarityInvert = w[cmp_ctrl_pkg::POLARITY_BIT];
    c.edgeSelect = w[cmp_ctrl_pkg::EDGE_LSB +: 2];
    c.positiveSelect = w[cmp_ctrl_pkg::POSSEL_BIT];
    c.negativeSelect = w[cmp_ctrl_pkg::NEGSEL_LSB +: 2];
    return c;
  endfunction

  // Result path: gated and inverted after the synchroniser, so pin, status
  // and edge detector all see one value
  assign shaped = (sync2_r & ctrl_r.enable) ^ ctrl_r.polarityInvert;

  always_comb begin
    edgePulse = 1'b0;
    case (ctrl_r.edgeSelect)
      cmp_ctrl_pkg::EDGE_RISE: edgePulse = shaped & ~prev_r;
      cmp_ctrl_pkg::EDGE_FALL: edgePulse = ~shaped & prev_r;
      cmp_ctrl_pkg::EDGE_BOTH: edgePulse = shaped ^ prev_r;
      cmp_ctrl_pkg::EDGE_NONE: edgePulse = 1'b0;
      default: edgePulse = 1'b0;
    endcase
    if (!ctrl_r.enable) begin
      edgePulse = 1'b0;
    end
  end

  // Write channel
  always_comb begin
    logic [31:0] merged;
    merged = 32'h0000_0000;
    wState_nxt = wState_r;
    awHave_nxt = awHave_r;
    wHave_nxt = wHave_r;
    awAddr_nxt = awAddr_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bResp_nxt = bResp_r;
    ctrl_nxt = ctrl_r;
    status_nxt = status_r;
    mask_nxt = mask_r;
    case (wState_r)
      W_IDLE, W_HAVE: begin
        if (s_axi_awvalid && !awHave_r) begin
          awHave_nxt = 1'b1;
          awAddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wHave_r) begin
          wHave_nxt = 1'b1;
          wData_nxt = s_axi_wdata;
          wStrb_nxt = s_axi_wstrb;
        end
        wState_nxt = (awHave_nxt || wHave_nxt) ? W_HAVE : W_IDLE;
        if (awHave_r && wHave_r) begin
          bResp_nxt = cmp_ctrl_pkg::RESP_OKAY;
          case (awAddr_r)
            cmp_ctrl_pkg::CONTROL_OFS: begin
              merged = merge(ctrlWord(ctrl_r, 1'b0), wData_r, wStrb_r);
              ctrl_nxt = toCtrl(merged &
                  cmp_ctrl_pkg::CONTROL_WMASK);
            end
            cmp_ctrl_pkg::STATUS_OFS: begin
              if (wStrb_r[0] && wData_r[0]) begin
                status_nxt = 1'b0;
              end
            end
            cmp_ctrl_pkg::MASK_OFS: begin
              if (wStrb_r[0]) begin
                mask_nxt = wData_r[0];
              end
            end
            default: bResp_nxt = cmp_ctrl_pkg::RESP_SLVERR;
          endcase
          awHave_nxt = 1'b0;
          wHave_nxt = 1'b0;
          wState_nxt = W_RESP;
        end
      end
      W_RESP: begin
        if (s_axi_bready) begin
          wState_nxt = W_IDLE;
        end
      end
      default: wState_nxt = W_IDLE;
    endcase
    if (edgePulse) begin
      status_nxt = 1'b1;
    end
    // Handshake outputs registered from the next state
    awReady_nxt = (wState_nxt != W_RESP) && !awHave_nxt;
    wReady_nxt = (wState_nxt != W_RESP) && !wHave_nxt;
    bValid_nxt = (wState_nxt == W_RESP);
  end

  // Read channel
  always_comb begin
    rValid_nxt = rValid_r;
    rData_nxt = rData_r;
    rResp_nxt = rResp_r;
    if (rValid_r && s_axi_rready) begin
      rValid_nxt = 1'b0;
    end else if (!rValid_r && s_axi_arvalid) begin
      rValid_nxt = 1'b1;
      rResp_nxt = cmp_ctrl_pkg::RESP_OKAY;
      case (s_axi_araddr)
        cmp_ctrl_pkg::CONTROL_OFS: begin
          rData_nxt = ctrlWord(ctrl_r, shaped);
        end
        cmp_ctrl_pkg::STATUS_OFS: rData_nxt = {31'h0000_0000, status_r};
        cmp_ctrl_pkg::MASK_OFS: rData_nxt = {31'h0000_0000, mask_r};
        default: begin
          rData_nxt = 32'h0000_0000;
          rResp_nxt = cmp_ctrl_pkg::RESP_SLVERR;
        end
      endcase
    end
    arReady_nxt = !rValid_nxt;
  end

  // Pin, interrupt and edge history
  always_comb begin
    prev_nxt = shaped;
    // Pin enable moves in the same cycle as the analogue enable
    pinOe_nxt = ctrl_nxt.enable & ctrl_nxt.driveEnable;
    pin_nxt = pinOe_nxt & shaped;
    irq_nxt = status_nxt & mask_nxt;
  end

  // Write side, control, status and mask
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= toCtrl(cmp_ctrl_pkg::CONTROL_RESET);
      wState_r <= W_IDLE;
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      bResp_r <= cmp_ctrl_pkg::RESP_OKAY;
      status_r <= 1'b0;
      mask_r <= 1'b0;
      awReady_r <= 1'b1;
      wReady_r <= 1'b1;
      bValid_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      wState_r <= wState_nxt;
      awHave_r <= awHave_nxt;
      wHave_r <= wHave_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bResp_r <= bResp_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      awReady_r <= awReady_nxt;
      wReady_r <= wReady_nxt;
      bValid_r <= bValid_nxt;
    end
  end

  // Read side
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rValid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= cmp_ctrl_pkg::RESP_OKAY;
      arReady_r <= 1'b1;
    end else begin
      rValid_r <= rValid_nxt;
      rData_r <= rData_nxt;
      rResp_r <= rResp_nxt;
      arReady_r <= arReady_nxt;
    end
  end

  // Raw core output crosses into sys_clk through two stages
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= comparatorResult;
      sync2_r <= sync1_r;
      prev_r <= prev_nxt;
    end
  end

  // Pin and interrupt outputs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_r <= 1'b0;
      pinOe_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
      pinOe_r <= pinOe_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Analogue steering registered from the next control value, cleared to zero in reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      analogControl <= '0;
    end else begin
      analogControl.enable <= ctrl_nxt.enable;
      analogControl.positiveSelect <= ctrl_nxt.positiveSelect;
      analogControl.negativeSelect <= ctrl_nxt.negativeSelect;
    end
  end

  assign s_axi_awready = awReady_r;
  assign s_axi_wready = wReady_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
  assign resultOutputPin = pin_r;
  assign resultOutputPinOe = pinOe_r;
  assign irq = irq_r;

endmodule

// file: test/cmp_core_model.sv
// Behavioural analogue comparator core.
// The bench picks the compared level; the core obeys only analogControl.enable.
`timescale 1ns/1ns
module cmp_core_model (
  // Control from the wrapper
  input cmp_ctrl_pkg::analog_s analogControl,
  // Level chosen by the bench
  input wire logic level,
  // Raw comparator output
  output logic comparatorResult
);
  // Powered down gives no valid answer, so show the wrong level
  assign comparatorResult = analogControl.enable ? level : !level;
endmodule

// file: test/cmp_ctrl_properties.sv
// Port checker for the comparator control wrapper.
// Bound to the top module; one clock domain, async low reset.
`timescale 1ns/1ns
module cmp_ctrl_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Bus answers
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core and pin
  input cmp_ctrl_pkg::analog_s analogControl,
  input wire logic resultOutputPin,
  input wire logic resultOutputPinOe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rdAnswer;
    ##1 s_axi_rvalid;
  endsequence
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  read_answer_a: assert property (rdTaken |-> rdAnswer)
    else $error("read not answered");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  read_accept_a: assert property (s_axi_arready != s_axi_rvalid)
    else $error("arready wrong");
  reserved_zero_a: assert property (s_axi_rvalid |->
    (s_axi_rdata & ~(cmp_ctrl_pkg::CONTROL_WMASK | 32'h0000_0100)) == 32'h0)
    else $error("reserved bit set");
  error_data_a: assert property (s_axi_rvalid &&
    s_axi_rresp == cmp_ctrl_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read not zero");
  pin_quiet_a: assert property (!resultOutputPinOe |-> !resultOutputPin)
    else $error("pin carries result");
  drive_enable_a: assert property (resultOutputPinOe |->
    analogControl.enable) else $error("pin driven while off");
endmodule

bind comparator_control_interrupt cmp_ctrl_properties props (.sys_clk,
  .reset_n, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .analogControl, .resultOutputPin, .resultOutputPinOe);

// file: test/comparator_control_interrupt_tb.sv
// Bench for the comparator wrapper over AXI4-Lite.
// Assumes the core model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module comparator_control_interrupt_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, level = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, comparatorResult, resultOutputPin;
  logic resultOutputPinOe, irq, inv, dir, ex;
  logic [1:0] s_axi_bresp, s_axi_rresp, s;
  cmp_ctrl_pkg::analog_s analogControl;
  int num_errors = 0, n_tests = 0, t = 0;
  always #25 sys_clk = ~sys_clk;
  comparator_control_interrupt DUT (.sys_clk, .reset_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .comparatorResult, .analogControl, .resultOutputPin,
    .resultOutputPinOe, .irq);
  cmp_core_model core (.analogControl, .level, .comparatorResult);
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic limit(input int n);
    if (n >= 50) begin
      num_errors++;
      $display("unexpected at %0t: no answer", $time);
      results();
    end
  endtask
  task automatic done();
    t++;
    $display("test %0d done", t);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
    input logic [1:0] r = cmp_ctrl_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    limit(n);
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e,
    input logic [1:0] r = cmp_ctrl_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    limit(n);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(4'h0, cmp_ctrl_pkg::CONTROL_RESET);
    done();
    wr(4'h0, 32'hFFFF_DFFF);
    rd(4'h0, 32'h0000_C0D3);
    chk({28'h0, analogControl}, 32'h0000_000F);
    chk({30'h0, resultOutputPinOe, resultOutputPin}, 32'h2);
    level <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(4'h0, 32'h0000_C1D3);
    chk({30'h0, resultOutputPinOe, resultOutputPin}, 32'h3);
    wr(4'h0, 32'h0000_E0D3);
    repeat (6) @(posedge sys_clk);
    rd(4'h0, 32'h0000_E0D3);
    chk({30'h0, resultOutputPinOe, resultOutputPin}, 32'h2);
    done();
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      wr(4'h0, {16'h0, 8'h80, 3'h0, s[0], 2'h0, s});
      chk({28'h0, analogControl}, {28'h0, 1'b1, s[0], s});
    end
    wr(4'h0, 32'h0000_4012);
    rd(4'h0, 32'h0000_4012);
    chk({28'h0, analogControl}, 32'h0000_0006);
    chk({30'h0, resultOutputPinOe, resultOutputPin}, 32'h0);
    done();
    wr(cmp_ctrl_pkg::MASK_OFS, 32'h1);
    for (int c = 0; c < 16; c++) begin
      {inv, s, dir} = 4'(c);
      level <= !dir;
      wr(4'h0, {16'h0, 2'h2, inv, 5'h0, s, 6'h0});
      repeat (6) @(posedge sys_clk);
      wr(cmp_ctrl_pkg::STATUS_OFS, 32'h1);
      level <= dir;
      repeat (6) @(posedge sys_clk);
      ex = (dir ^ inv) ? s[0] : s[1];
      rd(cmp_ctrl_pkg::STATUS_OFS, {31'h0, ex});
      chk({31'h0, irq}, {31'h0, ex});
    end
    wr(cmp_ctrl_pkg::MASK_OFS, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    wr(cmp_ctrl_pkg::STATUS_OFS, 32'h1);
    rd(cmp_ctrl_pkg::STATUS_OFS, 32'h0);
    done();
    wr(4'hC, 32'hFFFF_FFFF, cmp_ctrl_pkg::RESP_SLVERR);
    rd(4'hC, 32'h0, cmp_ctrl_pkg::RESP_SLVERR);
    done();
    results();
  end
endmodule
